// [logic/pct_channel.sv]
// Compare/capture pulse timer channel with AHB-Lite register slave
`timescale 1ns/10ps
// Summary of operation
// - Divide count clock by two to divider power, slow source capped at code 8
// - Two-bit source selects RC, slow, fast, external
// - Multi mode bit in clock control
// - Gate bit supplies or stops count clock
// - Half clock mode bit at six
// - Counter select picks one of four counters
// - Buffer bit buffers compares; one-shot or repeat
// - Clear bit zeroes counter, reads zero
// - Run bit counts, zero holds
// - Capture trigger: none, rise, fall, both
// - Unit B has own capture trigger
// - Output B waveform independent, same codes
// - Output B invert bit
// - Unit A capture or compare mode
// - Unit B capture or compare mode
// - Two sixteen-bit data registers reset zero
// - Six interrupt enable bits
// - Events set flags, write one clears
module pct_channel
  import pct_pkg::*;
#(
  parameter logic [1:0] CHAN_ID = 2'h0
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Count clock sources, one-cycle ticks or a level
  input wire logic rc_osc_tick,
  input wire logic slow_osc_tick,
  input wire logic fast_osc_tick,
  input wire logic ext_clk_in,
  // Counters of the other channels
  input wire logic [3:0][15:0] peer_count,
  // Capture inputs
  input wire logic capture_a_in,
  input wire logic capture_b_in,
  // Pulse outputs and request
  output logic timer_output_a,
  output logic timer_output_b,
  output logic irq
);

  // ************************************************************
  // Helpers
  // ************************************************************

  // Edge match against a two-bit trigger code
  function automatic logic edge_hit(input logic [1:0] trg, input logic rise,
                                    input logic fall);
    edge_hit = (trg[0] & rise) | (trg[1] & fall);
  endfunction

  // ************************************************************
  // Registers and state
  // ************************************************************
  pct_clk_t clk_ff; // Count clock control
  pct_ctl_t ctl_ff; // Counter control
  pct_ccc_t ccc_ff; // Compare/capture control
  logic [15:0] cnt_ff; // Own counter
  logic [15:0] unit_a_ff; // Unit A data
  logic [15:0] unit_b_ff; // Unit B data
  logic [15:0] shadow_a_ff; // Active buffered compare A
  logic [15:0] shadow_b_ff; // Active buffered compare B
  logic [5:0] ien_ff; // Interrupt enables
  logic [5:0] flg_ff; // Interrupt flags
  logic irq_ff; // Request
  logic wave_a_ff; // Output A waveform state
  logic wave_b_ff; // Output B waveform state
  logic out_a_ff; // Output A pin
  logic out_b_ff; // Output B pin
  logic half_ff; // Half clock phase
  logic ext_q_ff; // Previous external clock
  logic cap_a_q_ff; // Previous capture A input
  logic cap_b_q_ff; // Previous capture B input
  logic [15:0] sel_q_ff; // Previous selected counter
  // Bus state
  logic wr_ff; // Write data phase
  logic rd_ff; // Read wait cycle
  logic [15:0] adr_ff; // Latched register index
  logic [31:0] hrdata_ff; // Read data

  // ************************************************************
  // Bus slave
  // ************************************************************
  logic acc; // Accepted address phase
  logic [15:0] wd; // Write data, low half
  logic wr_clk, wr_ctl, wr_ccc, wr_ua, wr_ub, wr_ien, wr_ifl;

  assign acc = hsel & htrans[1] & hready;
  assign wd = hwdata[15:0];
  assign wr_clk = wr_ff && adr_ff == PCT_IDX_CLK;
  assign wr_ctl = wr_ff && adr_ff == PCT_IDX_CTL;
  assign wr_ccc = wr_ff && adr_ff == PCT_IDX_CCC;
  assign wr_ua = wr_ff && adr_ff == PCT_IDX_UA;
  assign wr_ub = wr_ff && adr_ff == PCT_IDX_UB;
  assign wr_ien = wr_ff && adr_ff == PCT_IDX_IEN;
  assign wr_ifl = wr_ff && adr_ff == PCT_IDX_IFL;
  // Reads wait one cycle, writes finish at once
  assign hreadyout = ~rd_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      adr_ff <= '0;
    end else begin
      wr_ff <= acc & hwrite;
      rd_ff <= acc & ~hwrite;
      if (acc) begin
        adr_ff <= haddr[17:2];
      end
    end
  end

  // Read mux, unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= '0;
    end else if (rd_ff) begin
      unique case (adr_ff)
        PCT_IDX_CLK: hrdata_ff <= {24'h00_0000, clk_ff};
        PCT_IDX_CTL: hrdata_ff <= {25'h000_0000, ctl_ff};
        PCT_IDX_CNT: hrdata_ff <= {16'h0000, cnt_ff};
        PCT_IDX_CCC: hrdata_ff <= {16'h0000, ccc_ff};
        PCT_IDX_UA: hrdata_ff <= {16'h0000, unit_a_ff};
        PCT_IDX_UB: hrdata_ff <= {16'h0000, unit_b_ff};
        PCT_IDX_IEN: hrdata_ff <= {26'h000_0000, ien_ff};
        PCT_IDX_IFL: hrdata_ff <= {26'h000_0000, flg_ff};
        default: hrdata_ff <= '0;
      endcase
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************

  // Clock, capture and enable configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_ff <= PCT_CLK_RST;
      ccc_ff <= PCT_CCC_RST;
      ien_ff <= '0;
    end else begin
      if (wr_clk) begin
        clk_ff <= pct_clk_t'(wd[7:0]);
      end
      if (wr_ccc) begin
        ccc_ff <= pct_ccc_t'(wd & 16'hf3f3);
      end
      if (wr_ien) begin
        ien_ff <= wd[5:0];
      end
    end
  end

  // ************************************************************
  // Count clock
  // ************************************************************
  logic src_tick; // Selected source tick
  logic [3:0] div_eff; // Divider code in use
  logic pre_tick; // Divided enable
  logic cnt_tick; // Counter advance enable
  logic ext_rise; // External clock rising edge

  assign ext_rise = ext_clk_in & ~ext_q_ff;

  // Source choice and slow oscillator divider limit
  always_comb begin
    unique case (clk_ff.source)
      PCT_SRC_RC: src_tick = rc_osc_tick;
      PCT_SRC_SLOW: src_tick = slow_osc_tick;
      PCT_SRC_FAST: src_tick = fast_osc_tick;
      PCT_SRC_EXT: src_tick = ext_rise;
    endcase
    div_eff = clk_ff.divider;
    if (clk_ff.source == PCT_SRC_SLOW && div_eff > PCT_DIV_SLOW_MAX) begin
      div_eff = PCT_DIV_SLOW_MAX;
    end
  end

  // Divider for the count clock
  pct_prescaler u_pre (
    .hclk(hclk),
    .hresetn(hresetn),
    .gate(clk_ff.clock_gate),
    .src_tick(src_tick),
    .divider(div_eff),
    .tick(pre_tick)
  );

  // Half clock mode counts on every second divided tick
  assign cnt_tick = pre_tick & (~ctl_ff.half_rate | half_ff);

  // Edge history for external clock, captures and half phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_q_ff <= 1'b0;
      cap_a_q_ff <= 1'b0;
      cap_b_q_ff <= 1'b0;
      half_ff <= 1'b0;
    end else begin
      ext_q_ff <= ext_clk_in;
      cap_a_q_ff <= capture_a_in;
      cap_b_q_ff <= capture_b_in;
      if (pre_tick) begin
        half_ff <= ~half_ff;
      end
    end
  end

  // ************************************************************
  // Counter
  // ************************************************************
  logic [15:0] cmp_a; // Compare A in use
  logic [15:0] cmp_b; // Compare B in use
  logic wrap; // Own counter hits compare B
  logic clr_req; // Software clear

  assign cmp_a = ctl_ff.buffering ? shadow_a_ff : unit_a_ff;
  assign cmp_b = ctl_ff.buffering ? shadow_b_ff : unit_b_ff;
  assign wrap = cnt_tick & ctl_ff.run & (cnt_ff == cmp_b);
  assign clr_req = wr_ctl & wd[PCT_CTL_CLR_BIT];

  // Counter value and its run control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= PCT_RST_16;
      ctl_ff <= PCT_CTL_RST;
    end else begin
      if (wr_ctl) begin
        ctl_ff <= pct_ctl_t'(wd[6:0] & 7'h7d);
      end else if (wrap && ctl_ff.single_shot) begin
        ctl_ff.run <= 1'b0;
      end
      if (clr_req) begin
        cnt_ff <= PCT_RST_16;
      end else if (wrap) begin
        cnt_ff <= PCT_RST_16;
      end else if (cnt_tick && ctl_ff.run) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end

  // Buffered compare values load at each counter wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shadow_a_ff <= PCT_RST_16;
      shadow_b_ff <= PCT_RST_16;
    end else if (wrap || clr_req || !ctl_ff.buffering) begin
      shadow_a_ff <= unit_a_ff;
      shadow_b_ff <= unit_b_ff;
    end
  end

  // ************************************************************
  // Compare and capture
  // ************************************************************
  logic [15:0] sel_cnt; // Counter seen by comparators
  logic moved; // Selected counter changed
  logic hit_a, hit_b; // Compare matches
  logic cap_a, cap_b; // Capture events

  // Multi mode follows the chosen counter, own one otherwise
  assign sel_cnt = (clk_ff.multi_mode && ctl_ff.choice != CHAN_ID) ?
                   peer_count[ctl_ff.choice] : cnt_ff;
  assign moved = sel_cnt != sel_q_ff;
  assign hit_a = moved & (sel_cnt == cmp_a) & ~ccc_ff.func_a;
  assign hit_b = moved & (sel_cnt == cmp_b) & ~ccc_ff.func_b;
  assign cap_a = ccc_ff.func_a & edge_hit(ccc_ff.cap_a_edge,
                 capture_a_in & ~cap_a_q_ff, ~capture_a_in & cap_a_q_ff);
  assign cap_b = ccc_ff.func_b & edge_hit(ccc_ff.cap_b_edge,
                 capture_b_in & ~cap_b_q_ff, ~capture_b_in & cap_b_q_ff);

  // Unit data: software writes, captures latch the counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_a_ff <= PCT_RST_16;
      unit_b_ff <= PCT_RST_16;
      sel_q_ff <= PCT_RST_16;
    end else begin
      sel_q_ff <= sel_cnt;
      if (cap_a) begin
        unit_a_ff <= sel_cnt;
      end else if (wr_ua) begin
        unit_a_ff <= wd;
      end
      if (cap_b) begin
        unit_b_ff <= sel_cnt;
      end else if (wr_ub) begin
        unit_b_ff <= wd;
      end
    end
  end

  // ************************************************************
  // Flags and request
  // ************************************************************
  logic [5:0] evt; // Events this cycle
  logic [5:0] nxt_flg; // Next flag value

  assign evt = {cap_b & flg_ff[3], cap_a & flg_ff[2], cap_b, cap_a, hit_b, hit_a};

  // Write one clears, a same-cycle event wins
  always_comb begin
    nxt_flg = flg_ff;
    if (wr_ifl) begin
      nxt_flg = flg_ff & ~wd[5:0];
    end
    nxt_flg = nxt_flg | evt;
  end

  // Flag register and request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flg_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      flg_ff <= nxt_flg;
      irq_ff <= |(flg_ff & ien_ff);
    end
  end
  assign irq = irq_ff;

  // ************************************************************
  // Waveform outputs
  // ************************************************************
  logic nxt_wave_a, nxt_wave_b; // Next waveform states

  // Waveform for one output from its mode
  function automatic logic wave_next(input logic [1:0] md, input logic cur,
                                     input logic ha, input logic hb);
    unique case (md)
      PCT_WAVE_OFF: wave_next = 1'b0;
      PCT_WAVE_AB: wave_next = ha ? 1'b1 : (hb ? 1'b0 : cur);
      PCT_WAVE_TA: wave_next = cur ^ ha;
      PCT_WAVE_TB: wave_next = cur ^ hb;
    endcase
  endfunction

  assign nxt_wave_a = wave_next(ccc_ff.wave_a, wave_a_ff, hit_a, hit_b);
  assign nxt_wave_b = wave_next(ccc_ff.wave_b, wave_b_ff, hit_a, hit_b);

  // Output pins carry the waveform through the invert bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_a_ff <= 1'b0;
      wave_b_ff <= 1'b0;
      out_a_ff <= 1'b0;
      out_b_ff <= 1'b0;
    end else begin
      wave_a_ff <= nxt_wave_a;
      wave_b_ff <= nxt_wave_b;
      out_a_ff <= nxt_wave_a ^ ccc_ff.inv_a;
      out_b_ff <= nxt_wave_b ^ ccc_ff.inv_b;
    end
  end
  assign timer_output_a = out_a_ff;
  assign timer_output_b = out_b_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_gate_off;
    !clk_ff.clock_gate ##1 !clk_ff.clock_gate;
  endsequence

  property p_gate_stop;
    s_gate_off |-> !pre_tick;
  endproperty
  a_gate_stop: assert property (p_gate_stop)
    else $error("count tick while clock gated");

  property p_clear;
    clr_req |=> cnt_ff == 16'h0000;
  endproperty
  a_clear: assert property (p_clear)
    else $error("counter not cleared");

  property p_hold;
    !ctl_ff.run && !clr_req |=> $stable(cnt_ff);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved while stopped");

  property p_flag_a;
    hit_a |=> flg_ff[0] ##1 irq_ff == $past(ien_ff[0]) || irq_ff;
  endproperty
  a_flag_a: assert property (p_flag_a)
    else $error("match A flag missing");

  property p_irq;
    |(flg_ff & ien_ff) |=> irq_ff;
  endproperty
  a_irq: assert property (p_irq)
    else $error("request not raised");

  property p_cap;
    cap_a |=> unit_a_ff == $past(sel_cnt) && flg_ff[2];
  endproperty
  a_cap: assert property (p_cap)
    else $error("capture A value wrong");

  property p_overrun;
    cap_b && flg_ff[3] |=> flg_ff[5];
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun B not flagged");

  property p_off_inv;
    ccc_ff.wave_a == PCT_WAVE_OFF |=> timer_output_a == $past(ccc_ff.inv_a);
  endproperty
  a_off_inv: assert property (p_off_inv)
    else $error("output A wrong in off mode");

  property p_toggle_b;
    ccc_ff.wave_b == PCT_WAVE_TB && hit_b |=> wave_b_ff != $past(wave_b_ff);
  endproperty
  a_toggle_b: assert property (p_toggle_b)
    else $error("output B did not toggle");

endmodule

// [logic/pct_pkg.sv]
// Package for the compare/capture pulse timer channel: register map, layouts, constants
package pct_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [15:0] PCT_IDX_CLK = 16'h5068; // Count clock control
  localparam logic [15:0] PCT_IDX_CTL = 16'h5400; // Counter control
  localparam logic [15:0] PCT_IDX_CNT = 16'h5402; // Counter value
  localparam logic [15:0] PCT_IDX_CCC = 16'h5404; // Compare/capture control
  localparam logic [15:0] PCT_IDX_UA = 16'h5406; // Unit A data
  localparam logic [15:0] PCT_IDX_UB = 16'h5408; // Unit B data
  localparam logic [15:0] PCT_IDX_IEN = 16'h540a; // Interrupt enable
  localparam logic [15:0] PCT_IDX_IFL = 16'h540c; // Interrupt flags

  // ************************************************************
  // Field codes and reset values
  // ************************************************************
  localparam logic [1:0] PCT_SRC_RC = 2'h0;   // Internal RC oscillator
  localparam logic [1:0] PCT_SRC_SLOW = 2'h1; // Slow crystal oscillator
  localparam logic [1:0] PCT_SRC_FAST = 2'h2; // Fast crystal oscillator
  localparam logic [1:0] PCT_SRC_EXT = 2'h3;  // External clock input
  localparam logic [3:0] PCT_DIV_SLOW_MAX = 4'h8; // Largest slow divider code
  localparam logic [1:0] PCT_WAVE_OFF = 2'h0; // Output held off
  localparam logic [1:0] PCT_WAVE_AB = 2'h1;  // Rise on A, fall on B
  localparam logic [1:0] PCT_WAVE_TA = 2'h2;  // Toggle on A
  localparam logic [1:0] PCT_WAVE_TB = 2'h3;  // Toggle on B
  localparam int PCT_CTL_CLR_BIT = 1;         // Write-only counter clear
  localparam int PCT_FLG_W = 6;               // Flag and enable width
  localparam int PCT_CNT_W = 16;              // Counter width
  localparam logic [15:0] PCT_RST_16 = 16'h0000; // Reset of 16-bit values

  // ************************************************************
  // Register layouts
  // ************************************************************
  typedef struct packed {
    logic [3:0] divider;   // Divide by 2**divider
    logic [1:0] source;    // Count clock source
    logic multi_mode;      // Multi-counter mode
    logic clock_gate;      // Count clock enable
  } pct_clk_t;

  typedef struct packed {
    logic half_rate;       // Half clock mode
    logic [1:0] choice;    // Counter used by comparators
    logic buffering;       // Compare buffering
    logic single_shot;     // One-shot count
    logic clear;           // Always stored as zero
    logic run;             // Counter run
  } pct_ctl_t;

  typedef struct packed {
    logic [1:0] cap_b_edge;  // Capture B trigger
    logic [1:0] wave_b;      // Output B waveform
    logic [1:0] rsv_hi;      // Reads zero
    logic inv_b;             // Output B invert
    logic func_b;            // Unit B capture mode
    logic [1:0] cap_a_edge;  // Capture A trigger
    logic [1:0] wave_a;      // Output A waveform
    logic [1:0] rsv_lo;      // Reads zero
    logic inv_a;             // Output A invert
    logic func_a;            // Unit A capture mode
  } pct_ccc_t;

  localparam pct_clk_t PCT_CLK_RST = '0; // Clock control reset
  localparam pct_ctl_t PCT_CTL_RST = '0; // Counter control reset
  localparam pct_ccc_t PCT_CCC_RST = '0; // Compare/capture reset

endpackage

// [logic/pct_prescaler.sv]
// Count clock divider that turns source ticks into divided count enables
`timescale 1ns/10ps
module pct_prescaler
  import pct_pkg::*;
#(
  parameter int DIV_W = 15
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic gate,
  input wire logic src_tick,
  input wire logic [3:0] divider,
  // Divided enable
  output logic tick
);

  logic [DIV_W-1:0] cnt_ff; // Source tick count
  logic tick_ff; // Divided enable pulse
  logic [DIV_W-1:0] mask; // Terminal count

  // Terminal count is 2**divider minus one
  assign mask = DIV_W'((32'd1 << divider) - 32'd1);
  assign tick = tick_ff;

  // Count source ticks while the clock is gated on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (!gate) begin
      // Stopped clock holds the divider at zero
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (src_tick && cnt_ff >= mask) begin
      cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      if (src_tick) begin
        cnt_ff <= cnt_ff + DIV_W'(1);
      end
      tick_ff <= 1'b0;
    end
  end

endmodule

// [tb/pct_tb.sv]
// Self-checking bench for the pulse timer channel over AHB-Lite
`timescale 1ns/10ps
module tb
  import pct_pkg::*;
;
  // Bus, pins and bookkeeping
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, out_a, out_b;
  logic cap_a, cap_b;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [3:0] src_v; // Source ticks: rc, slow, fast, external level
  logic [3:0][15:0] peers; // Counters of the other channels
  int bad_count, compares;
  int cyc = 0;
  localparam logic [15:0] IDX_TAB [9] = '{PCT_IDX_CLK, PCT_IDX_CTL, PCT_IDX_CNT, PCT_IDX_CCC,
    PCT_IDX_UA, PCT_IDX_UB, PCT_IDX_IEN, PCT_IDX_IFL, 16'h0000};
  assign hready = hreadyout; // Single slave drives bus ready
  pct_channel dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rc_osc_tick(src_v[0]),
    .slow_osc_tick(src_v[1]), .fast_osc_tick(src_v[2]), .ext_clk_in(src_v[3]),
    .peer_count(peers), .capture_a_in(cap_a), .capture_b_in(cap_b),
    .timer_output_a(out_a), .timer_output_b(out_b), .irq(irq));
  // Clock of 4 ns
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  // One single AHB transfer; waits on hready at each phase
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    logic ok;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0000, idx, 2'h0};
    do begin @(negedge hclk); ok = hreadyout; @(posedge hclk); end while (ok !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge hclk);
      ok = hreadyout;
      rd = hrdata;
      @(posedge hclk);
    end while (ok !== 1'b1);
  endtask
  // Register compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Pin compare once registered outputs have settled
  task automatic pin(input logic exp, input int which);
    logic got;
    repeat (3) @(negedge hclk);
    got = (which == 0) ? out_a : (which == 1) ? out_b : irq;
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rc(input logic [15:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // Pulses n ticks on one source, then lets the counter settle
  task automatic tk(input int s, input int n);
    repeat (n) begin
      @(posedge hclk);
      src_v[s] <= 1'b1;
      @(posedge hclk);
      src_v[s] <= 1'b0;
    end
    repeat (4) @(posedge hclk);
  endtask
  // Sets both capture levels
  task automatic cp(input logic a, input logic b);
    @(posedge hclk);
    cap_a <= a;
    cap_b <= b;
    repeat (3) @(posedge hclk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = '0; src_v = 4'h0; cap_a = 1'b0; cap_b = 1'b0;
    peers = '0;
    peers[1] = 16'h1234;
    bad_count = 0;
    compares = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (IDX_TAB[i]) rc(IDX_TAB[i], 32'h0000_0000);
    pin(1'b0, 2);
    done("reset");
    wr(PCT_IDX_CLK, 32'hffff_ffff);
    rc(PCT_IDX_CLK, 32'h0000_00ff);
    wr(PCT_IDX_CTL, 32'h0000_ffff);
    rc(PCT_IDX_CTL, 32'h0000_007d);
    wr(PCT_IDX_CCC, 32'h0000_ffff);
    rc(PCT_IDX_CCC, 32'h0000_f3f3);
    wr(PCT_IDX_IEN, 32'h0000_ffff);
    rc(PCT_IDX_IEN, 32'h0000_003f);
    wr(16'h0000, 32'h0000_5a5a);
    rc(16'h0000, 32'h0000_0000);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    wr(PCT_IDX_CTL, 32'h0000_0000);
    wr(PCT_IDX_CLK, 32'h0000_0000);
    wr(PCT_IDX_CCC, 32'h0000_0000);
    wr(PCT_IDX_IEN, 32'h0000_0000);
    done("access");
    wr(PCT_IDX_UB, 32'h0000_ffff);
    rc(PCT_IDX_UB, 32'h0000_ffff);
    wr(PCT_IDX_CLK, 32'h0000_0021);
    wr(PCT_IDX_CTL, 32'h0000_0003);
    tk(0, 8);
    rc(PCT_IDX_CNT, 32'h0000_0002);
    tk(1, 8);
    rc(PCT_IDX_CNT, 32'h0000_0002);
    wr(PCT_IDX_CTL, 32'h0000_0000);
    tk(0, 4);
    rc(PCT_IDX_CNT, 32'h0000_0002);
    for (int s = 0; s < 4; s++) begin
      wr(PCT_IDX_CLK, 32'(s * 4 + 1));
      wr(PCT_IDX_CTL, 32'h0000_0003);
      rc(PCT_IDX_CTL, 32'h0000_0001);
      tk(s, 3);
      rc(PCT_IDX_CNT, 32'h0000_0003);
    end
    wr(PCT_IDX_CLK, 32'h0000_000c);
    tk(3, 3);
    rc(PCT_IDX_CNT, 32'h0000_0003);
    wr(PCT_IDX_CLK, 32'h0000_0001);
    wr(PCT_IDX_CTL, 32'h0000_0043);
    tk(0, 4);
    rc(PCT_IDX_CNT, 32'h0000_0002);
    wr(PCT_IDX_CLK, 32'h0000_00f5);
    wr(PCT_IDX_CTL, 32'h0000_0003);
    tk(1, 512);
    rc(PCT_IDX_CNT, 32'h0000_0002);
    done("counting");
    wr(PCT_IDX_CLK, 32'h0000_0001);
    wr(PCT_IDX_UA, 32'h0000_0003);
    wr(PCT_IDX_UB, 32'h0000_0006);
    wr(PCT_IDX_CTL, 32'h0000_0003);
    wr(PCT_IDX_IFL, 32'h0000_003f);
    wr(PCT_IDX_CCC, 32'h0000_2210);
    pin(1'b0, 0);
    pin(1'b1, 1);
    tk(0, 3);
    pin(1'b1, 0);
    pin(1'b0, 1);
    rc(PCT_IDX_IFL, 32'h0000_0001);
    tk(0, 3);
    pin(1'b0, 0);
    rc(PCT_IDX_CNT, 32'h0000_0006);
    rc(PCT_IDX_IFL, 32'h0000_0003);
    pin(1'b0, 2);
    wr(PCT_IDX_IEN, 32'h0000_0001);
    pin(1'b1, 2);
    wr(PCT_IDX_IFL, 32'h0000_0001);
    rc(PCT_IDX_IFL, 32'h0000_0002);
    pin(1'b0, 2);
    wr(PCT_IDX_IEN, 32'h0000_0002);
    pin(1'b1, 2);
    wr(PCT_IDX_IFL, 32'h0000_0002);
    pin(1'b0, 2);
    tk(0, 1);
    rc(PCT_IDX_CNT, 32'h0000_0000);
    wr(PCT_IDX_CCC, 32'h0000_3032);
    pin(1'b1, 0);
    pin(1'b1, 1);
    tk(0, 6);
    pin(1'b0, 0);
    pin(1'b0, 1);
    done("compare");
    wr(PCT_IDX_IFL, 32'h0000_003f);
    wr(PCT_IDX_CCC, 32'h0000_8141);
    wr(PCT_IDX_CTL, 32'h0000_0003);
    tk(0, 2);
    cp(1'b1, 1'b1);
    rc(PCT_IDX_IFL, 32'h0000_0004);
    cp(1'b0, 1'b0);
    rc(PCT_IDX_IFL, 32'h0000_000c);
    rc(PCT_IDX_UA, 32'h0000_0002);
    rc(PCT_IDX_UB, 32'h0000_0002);
    wr(PCT_IDX_CCC, 32'h0000_c141);
    cp(1'b1, 1'b1);
    rc(PCT_IDX_IFL, 32'h0000_003c);
    wr(PCT_IDX_CLK, 32'h0000_0003);
    wr(PCT_IDX_CTL, 32'h0000_0011);
    cp(1'b0, 1'b0);
    rc(PCT_IDX_UB, 32'h0000_1234);
    rc(PCT_IDX_UA, 32'h0000_0002);
    done("capture");
    wr(PCT_IDX_CCC, 32'h0000_0000);
    wr(PCT_IDX_CLK, 32'h0000_0001);
    wr(PCT_IDX_UB, 32'h0000_0002);
    wr(PCT_IDX_CTL, 32'h0000_0007);
    tk(0, 5);
    rc(PCT_IDX_CNT, 32'h0000_0000);
    rc(PCT_IDX_CTL, 32'h0000_0004);
    wr(PCT_IDX_CTL, 32'h0000_000b);
    wr(PCT_IDX_UB, 32'h0000_0005);
    tk(0, 4);
    rc(PCT_IDX_CNT, 32'h0000_0001);
    done("modes");
    end_of_test();
  end
endmodule
